// ==== src/mux_input_word.sv ====
// Multiplexed four-channel analog input word with pointer-transfer words
//
// What this block does
// - All channel conversions share one data word, one channel at a time.
// - The word is presented as sixteen discrete input points.
// - Not busy with both select bits clear means the word holds channel 1.
// - Not busy, low select set, high select clear means channel 2 data.
// - Bipolar multiplexed mode: top point set for negative, clear for positive.
// - Bipolar magnitude runs 0 to 4095 both ways; sign carried separately.
// - Analog circuit failure shows as data zero with the top point set.
// - Pointer transfer returns 8000 when the analog circuitry has failed.
// - Multiplexed data is plain binary in the low twelve bits.
// - Pointer transfer delivers values in BCD form.
// - In bipolar mode, pointer transfer flags negative values with the BCD word's top bit.
//
// The implementer's own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module mux_input_word
	import mux_word_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// Wishbone register bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Conversion results from the converter logic
	input wire logic conv_valid_i,
	input wire logic [1:0] conv_chan_i,
	input wire logic [11:0] conv_mag_i,
	input wire logic conv_neg_i,
	input wire logic analog_fail_i,
	// Sixteen input points toward the host
	output logic [15:0] in_word_o,
	output logic channel_select_low_o,
	output logic channel_select_high_o,
	output logic sign_fault_point_o,
	// Interrupt
	output logic irq_o
);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [CH_W-1:0] next_chan(input logic [CH_W-1:0] cur,
		input logic [CH_W-1:0] last);
		return (cur >= last) ? {CH_W{1'b0}} : cur + {{(CH_W-1){1'b0}}, 1'b1};
	endfunction

	// ------------------------------------------------------------
	// Bus front end
	// ------------------------------------------------------------
	reg_access_if acc ();

	wb_reg_slave u_slave (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_dat_i(wb_dat_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.acc(acc)
	);

	// ------------------------------------------------------------
	// Registers and decode
	// ------------------------------------------------------------
	logic [CTRL_W-1:0] ctrl_q;
	logic [DIV_W-1:0] div_q;
	logic [IRQ_W-1:0] stat_q;
	logic [IRQ_W-1:0] stat_d;
	logic [IRQ_W-1:0] mask_q;

	wire wr = acc.req & acc.we;
	wire rd = acc.req & ~acc.we;
	wire hit_ctrl = acc.addr == ADR_CTRL;
	wire hit_div = acc.addr == ADR_DIV;
	wire hit_word = acc.addr == ADR_WORD;
	wire hit_stat = acc.addr == ADR_STAT;
	wire hit_mask = acc.addr == ADR_MASK;
	wire [ADR_W-1:0] ptr_off = acc.addr - ADR_PTR0;
	wire hit_ptr = (acc.addr >= ADR_PTR0) && (ptr_off < ADR_W'(NUM_CH * ADR_PTR_STEP)) &&
		((ptr_off % ADR_PTR_STEP) == 0);
	wire [CH_W-1:0] ptr_idx = CH_W'(ptr_off / ADR_PTR_STEP);

	wire enable = ctrl_q[CTRL_EN];
	wire bipolar = ctrl_q[CTRL_BIPOLAR];
	wire [CH_W-1:0] last_chan = ctrl_q[CTRL_CNT_LSB +: CH_W];

	wire [31:0] ctrl_merged = merge_bytes({{(32-CTRL_W){1'b0}}, ctrl_q}, acc.wdata, acc.sel);
	wire [31:0] div_merged = merge_bytes({{(32-DIV_W){1'b0}}, div_q}, acc.wdata, acc.sel);
	wire [31:0] mask_merged = merge_bytes({{(32-IRQ_W){1'b0}}, mask_q}, acc.wdata, acc.sel);

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_q <= CTRL_RST;
			div_q <= DIV_RST;
			mask_q <= MASK_RST;
		end else if (wr) begin
			if (hit_ctrl) begin
				ctrl_q <= ctrl_merged[CTRL_W-1:0];
			end
			if (hit_div) begin
				div_q <= div_merged[DIV_W-1:0];
			end
			if (hit_mask) begin
				mask_q <= mask_merged[IRQ_W-1:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Per-channel conversion store
	// ------------------------------------------------------------
	logic [DATA_W-1:0] mag_q [NUM_CH];
	logic [NUM_CH-1:0] neg_q;
	logic [NUM_CH-1:0] fresh_q;
	logic fail_meta_q;
	logic fail_q;
	logic [WORD_W-1:0] ptr_q [NUM_CH];
	logic [WORD_W-1:0] ptr_enc [NUM_CH];

	wire [NUM_CH-1:0] chan_mask = NUM_CH'((1 << (last_chan + 1)) - 1);
	wire sweep_done = ((fresh_q & chan_mask) == chan_mask);

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int c = 0; c < NUM_CH; c++) begin
				mag_q[c] <= 12'h000;
			end
			neg_q <= '0;
			fresh_q <= '0;
			fail_meta_q <= 1'b0;
			fail_q <= 1'b0;
		end else begin
			// Failure level comes from the analog side: two stages
			fail_meta_q <= analog_fail_i;
			fail_q <= fail_meta_q;
			if (sweep_done) begin
				fresh_q <= '0;
			end
			if (conv_valid_i) begin
				mag_q[conv_chan_i] <= conv_mag_i;
				neg_q[conv_chan_i] <= conv_neg_i;
				// A conversion in the clearing cycle still counts
				fresh_q[conv_chan_i] <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Pointer-transfer words, one per channel
	// ------------------------------------------------------------
	for (genvar g = 0; g < NUM_CH; g++) begin : g_ptr
		ptr_word_enc u_enc (
			.mag_i(mag_q[g]),
			.neg_i(neg_q[g]),
			.fail_i(fail_q),
			.bipolar_i(bipolar),
			.word_o(ptr_enc[g])
		);
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int c = 0; c < NUM_CH; c++) begin
				ptr_q[c] <= 16'h0000;
			end
		end else begin
			for (int c = 0; c < NUM_CH; c++) begin
				ptr_q[c] <= ptr_enc[c];
			end
		end
	end

	// ------------------------------------------------------------
	// Scan rate divider
	// ------------------------------------------------------------
	logic [DIV_W-1:0] div_cnt_q;
	wire tick = enable && (div_cnt_q == '0);

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div_cnt_q <= '0;
		end else if (!enable || tick) begin
			div_cnt_q <= div_q;
		end else begin
			div_cnt_q <= div_cnt_q - 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Scan sequencer: busy while switching, then show one channel
	// ------------------------------------------------------------
	scan_state_e state_q;
	scan_state_e state_d;
	logic [CH_W-1:0] chan_q;
	logic [WORD_W-1:0] word_q;

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (tick) begin
					state_d = ST_BUSY;
				end
			end
			ST_BUSY: begin
				if (!enable) begin
					state_d = ST_IDLE;
				end else if (tick) begin
					state_d = ST_SHOW;
				end
			end
			ST_SHOW: begin
				if (!enable) begin
					state_d = ST_IDLE;
				end else if (tick) begin
					state_d = ST_BUSY;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// Word fields for the channel about to be shown
	wire [CH_W-1:0] shown_chan = chan_q;
	wire shown_neg = bipolar & neg_q[shown_chan];
	wire [DATA_W-1:0] shown_data = fail_q ? {DATA_W{1'b0}} : mag_q[shown_chan];
	wire shown_top = fail_q | shown_neg;
	wire load_word = (state_q == ST_BUSY) && tick && enable;
	wire enter_busy = (state_d == ST_BUSY) && (state_q != ST_BUSY);

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= ST_IDLE;
			chan_q <= '0;
			word_q <= 16'h0000;
		end else begin
			state_q <= state_d;
			if (!enable) begin
				chan_q <= '0;
			end else if (enter_busy && state_q == ST_SHOW) begin
				chan_q <= next_chan(chan_q, last_chan);
			end
			if (enter_busy) begin
				word_q[BUSY_BIT] <= 1'b1;
			end else if (load_word) begin
				word_q[DATA_LSB +: DATA_W] <= shown_data;
				word_q[SEL_LO_BIT] <= shown_chan[0];
				word_q[SEL_HI_BIT] <= shown_chan[1];
				word_q[BUSY_BIT] <= 1'b0;
				word_q[SIGN_BIT] <= shown_top;
			end else if (state_q == ST_IDLE) begin
				word_q[BUSY_BIT] <= 1'b0;
			end
		end
	end

	// Sixteen input points; select bits copied straight from the word, not qualified by busy
	assign in_word_o = word_q;
	assign channel_select_low_o = word_q[SEL_LO_BIT];
	assign channel_select_high_o = word_q[SEL_HI_BIT];
	assign sign_fault_point_o = word_q[SIGN_BIT];

	// ------------------------------------------------------------
	// Interrupt status: read clears, a new event wins
	// ------------------------------------------------------------
	logic fail_seen_q;
	wire fail_rise = fail_q & ~fail_seen_q;
	wire [IRQ_W-1:0] events = {sweep_done, fail_rise, load_word};
	wire stat_rd = rd & hit_stat;

	assign stat_d = (stat_rd ? {IRQ_W{1'b0}} : stat_q) | events;

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stat_q <= '0;
			fail_seen_q <= 1'b0;
		end else begin
			stat_q <= stat_d;
			fail_seen_q <= fail_q;
		end
	end

	assign irq_o = |(stat_q & mask_q);

	// ------------------------------------------------------------
	// Read data selection
	// ------------------------------------------------------------
	wire [31:0] rd_ctrl = {{(32-CTRL_W){1'b0}}, ctrl_q};
	wire [31:0] rd_div = {{(32-DIV_W){1'b0}}, div_q};
	wire [31:0] rd_word = {{(32-WORD_W){1'b0}}, word_q};
	wire [31:0] rd_stat = {{(32-IRQ_W){1'b0}}, stat_q};
	wire [31:0] rd_mask = {{(32-IRQ_W){1'b0}}, mask_q};
	wire [31:0] rd_ptr = {{(32-WORD_W){1'b0}}, ptr_q[ptr_idx]};

	assign acc.rdata = hit_ctrl ? rd_ctrl :
		hit_div ? rd_div :
		hit_word ? rd_word :
		hit_stat ? rd_stat :
		hit_mask ? rd_mask :
		hit_ptr ? rd_ptr : 32'h0000_0000;
endmodule
`default_nettype wire

// ==== src/mux_word_pkg.sv ====
// Constants shared by the multiplexed analog input word design
package mux_word_pkg;
	// ----------------------------------------
	// Word layout
	// ----------------------------------------
	localparam int NUM_CH = 4;
	localparam int CH_W = 2;
	localparam int DATA_W = 12;
	localparam int WORD_W = 16;
	localparam int DATA_LSB = 0;
	localparam int SEL_LO_BIT = 12;
	localparam int SEL_HI_BIT = 13;
	localparam int BUSY_BIT = 14;
	localparam int SIGN_BIT = 15;
	localparam logic [WORD_W-1:0] PTR_FAULT_WORD = 16'h8000;
	localparam int PTR_NEG_BIT = 15;
	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam int ADR_W = 8;
	localparam logic [ADR_W-1:0] ADR_CTRL = 8'h00;
	localparam logic [ADR_W-1:0] ADR_DIV = 8'h04;
	localparam logic [ADR_W-1:0] ADR_WORD = 8'h08;
	localparam logic [ADR_W-1:0] ADR_STAT = 8'h0C;
	localparam logic [ADR_W-1:0] ADR_MASK = 8'h10;
	localparam logic [ADR_W-1:0] ADR_PTR0 = 8'h14;
	localparam int ADR_PTR_STEP = 4;
	// ----------------------------------------
	// Register fields and reset values
	// ----------------------------------------
	localparam int CTRL_EN = 0;
	localparam int CTRL_BIPOLAR = 1;
	localparam int CTRL_CNT_LSB = 4;
	localparam int CTRL_W = 6;
	localparam logic [CTRL_W-1:0] CTRL_RST = 6'h30;
	localparam int DIV_W = 16;
	localparam logic [DIV_W-1:0] DIV_RST = 16'h0064;
	localparam int IRQ_UPDATE = 0;
	localparam int IRQ_FAULT = 1;
	localparam int IRQ_SWEEP = 2;
	localparam int IRQ_W = 3;
	localparam logic [IRQ_W-1:0] MASK_RST = 3'h0;
	// ----------------------------------------
	// Scan sequencer states
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_BUSY = 3'b010,
		ST_SHOW = 3'b100
	} scan_state_e;
endpackage

// ==== src/ptr_word_enc.sv ====
// Pointer-transfer word encoder: BCD magnitude with sign or fault flag
`timescale 1ns/1ps
`default_nettype none
module ptr_word_enc
	import mux_word_pkg::*;
(
	input wire logic [DATA_W-1:0] mag_i,
	input wire logic neg_i,
	input wire logic fail_i,
	input wire logic bipolar_i,
	output logic [WORD_W-1:0] word_o
);
	function automatic logic [WORD_W-1:0] to_bcd(input logic [DATA_W-1:0] bin);
		logic [WORD_W+DATA_W-1:0] sh;
		sh = {{WORD_W{1'b0}}, bin};
		for (int i = 0; i < DATA_W; i++) begin
			for (int d = 0; d < 4; d++) begin
				if (sh[DATA_W+4*d +: 4] > 4'h4) begin
					sh[DATA_W+4*d +: 4] = sh[DATA_W+4*d +: 4] + 4'h3;
				end
			end
			sh = sh << 1;
		end
		return sh[DATA_W +: WORD_W];
	endfunction

	logic [WORD_W-1:0] bcd;
	assign bcd = to_bcd(mag_i);
	assign word_o = fail_i ? PTR_FAULT_WORD :
		(bipolar_i && neg_i) ? (bcd | PTR_FAULT_WORD) : bcd;
endmodule
`default_nettype wire

// ==== src/reg_access_if.sv ====
// Register access carrier between bus slave and register file
`timescale 1ns/1ps
`default_nettype none
interface reg_access_if;
	logic req;
	logic we;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic [3:0] sel;
	logic [31:0] rdata;
	modport bus (output req, output we, output addr, output wdata, output sel, input rdata);
	modport regs (input req, input we, input addr, input wdata, input sel, output rdata);
endinterface
`default_nettype wire

// ==== src/wb_reg_slave.sv ====
// Classic Wishbone slave front end, one wait state
`timescale 1ns/1ps
`default_nettype none
module wb_reg_slave (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// Wishbone
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Register side
	reg_access_if.bus acc
);
	logic ack_q;
	logic [31:0] dat_q;

	// Request taken once per cycle, blocked while ack is out
	assign acc.req = wb_cyc_i & wb_stb_i & ~ack_q;
	assign acc.we = wb_we_i;
	assign acc.addr = wb_adr_i;
	assign acc.wdata = wb_dat_i;
	assign acc.sel = wb_sel_i;
	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= acc.req;
			if (acc.req) begin
				dat_q <= acc.we ? 32'h0000_0000 : acc.rdata;
			end
		end
	end
endmodule
`default_nettype wire

// ==== test/host_scan_model.sv ====
// Host controller model scanning the sixteen input points
`timescale 1ns/1ps
`default_nettype none
module host_scan_model
	import mux_word_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic [WORD_W-1:0] word_i,
	output logic [NUM_CH-1:0][DATA_W-1:0] ch_data_o,
	output logic [NUM_CH-1:0] ch_neg_o
);
	wire logic [CH_W-1:0] chan = {word_i[SEL_HI_BIT], word_i[SEL_LO_BIT]};
	wire logic [DATA_W-1:0] value = word_i[DATA_W-1:0];
	always @(posedge ref_clk_i) begin
		if (!word_i[BUSY_BIT]) begin
			ch_data_o[chan] <= value;
			ch_neg_o[chan] <= word_i[SIGN_BIT];
		end
	end
endmodule
`default_nettype wire

// ==== test/mux_input_word_properties.sv ====
// Port-level checks on the multiplexed input word
`timescale 1ns/1ps
`default_nettype none
module mux_input_word_props
	import mux_word_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic analog_fail_i,
	input wire logic [15:0] in_word_o,
	input wire logic channel_select_low_o,
	input wire logic channel_select_high_o,
	input wire logic sign_fault_point_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	wire logic busy = in_word_o[BUSY_BIT];
	wire logic [1:0] chan = {in_word_o[SEL_HI_BIT], in_word_o[SEL_LO_BIT]};
	property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
	property p_ack_lat; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack_lat: assert property (p_ack_lat) else $error("ack late");
	property p_wr_zero; wb_ack_o && $past(wb_we_i) |-> wb_dat_o == 32'h0000_0000; endproperty
	a_wr_zero: assert property (p_wr_zero) else $error("write returned data");
	property p_points; {sign_fault_point_o, channel_select_high_o, channel_select_low_o} == {in_word_o[SIGN_BIT], chan}; endproperty
	a_points: assert property (p_points) else $error("point copies differ");
	property p_fault; analog_fail_i [*3] ##1 (analog_fail_i && $fell(busy)) |-> in_word_o[11:0] == 12'h000 && sign_fault_point_o; endproperty
	a_fault: assert property (p_fault) else $error("fault word wrong");
	property p_stand; !busy && !$past(busy) |-> $stable(in_word_o[11:0]); endproperty
	a_stand: assert property (p_stand) else $error("shown data moved");
	property p_hold; $rose(busy) |-> $stable(in_word_o[11:0]); endproperty
	a_hold: assert property (p_hold) else $error("data moved on busy");
	property p_step; $changed(chan) |-> !busy && (chan == 2'b00 || chan == $past(chan) + 2'b01); endproperty
	a_step: assert property (p_step) else $error("channel skipped");
endmodule
bind mux_input_word mux_input_word_props i_mux_input_word_props (.ref_clk_i, .rst_n_i, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_dat_o, .wb_ack_o, .analog_fail_i, .in_word_o, .channel_select_low_o, .channel_select_high_o,
	.sign_fault_point_o);
`default_nettype wire

// ==== test/testbench.sv ====
// Self-checking bench for the multiplexed analog input word
`timescale 1ns/1ps
`default_nettype none
module testbench
	import mux_word_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, cv = 1'b0, cneg = 1'b0, fail = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0, q;
	logic [1:0] cch = 2'h0;
	logic [11:0] cmag = 12'h000;
	wire logic [31:0] rdat;
	wire logic ack, irq;
	wire logic [15:0] word;
	wire logic [3:0][11:0] hdata;
	wire logic [3:0] hneg;
	int error_cnt = 0, compares = 0;
	logic [11:0] mags [4] = '{12'h4D2, 12'h237, 12'h059, 12'hFFF};
	logic [15:0] bcds [4] = '{16'h1234, 16'h0567, 16'h0089, 16'h4095};
	always #50 ref_clk = ~ref_clk;
	mux_input_word i_mux_input_word (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_dat_o(rdat), .wb_ack_o(ack),
		.conv_valid_i(cv), .conv_chan_i(cch), .conv_mag_i(cmag), .conv_neg_i(cneg), .analog_fail_i(fail),
		.in_word_o(word), .channel_select_low_o(), .channel_select_high_o(), .sign_fault_point_o(), .irq_o(irq));
	host_scan_model i_host_scan_model (.ref_clk_i(ref_clk), .word_i(word), .ch_data_o(hdata), .ch_neg_o(hneg));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		// Waits as long as it takes; only the watchdog ends a hang
		do begin
			@(posedge ref_clk);
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge ref_clk);
	endtask
	// Samples irq and busy away from the edge
	task automatic pins(input logic [1:0] exp);
		@(negedge ref_clk);
		chk({30'h0, irq, word[BUSY_BIT]}, {30'h0, exp}, "irq busy");
		@(posedge ref_clk);
	endtask
	task automatic t_regs();
		wb(ADR_CTRL, 1'b0, 0);
		chk(q, 32'h30, "ctrl");
		wb(ADR_DIV, 1'b0, 0);
		chk(q, 32'h64, "div");
		wb(ADR_MASK, 1'b0, 0);
		chk(q, 32'h0, "mask");
		wb(8'h40, 1'b0, 0);
		chk(q, 32'h0, "unmapped");
		wb(ADR_DIV, 1'b1, 32'h3);
		wb(ADR_DIV, 1'b0, 0);
		chk(q, 32'h3, "div wr");
		$display("t_regs done");
	endtask
	task automatic t_sweep(input logic bip);
		for (int i = 0; i < 4; i++) begin
			cv <= 1'b1;
			cch <= 2'(i);
			cmag <= mags[i];
			cneg <= 1'b1;
			@(posedge ref_clk);
			cv <= 1'b0;
			@(posedge ref_clk);
		end
		wb(ADR_CTRL, 1'b1, {26'h0, 2'b11, 2'b00, bip, 1'b1});
		wb(ADR_PTR0, 1'b1, 32'hFFFF);
		repeat (80) @(posedge ref_clk);
		for (int i = 0; i < 4; i++) begin
			chk({20'h0, hdata[i]}, {20'h0, mags[i]}, "host data");
			chk({31'h0, hneg[i]}, {31'h0, bip}, "host sign");
			wb(8'(ADR_PTR0 + ADR_PTR_STEP * i), 1'b0, 0);
			chk(q, {16'h0, bip, bcds[i][14:0]}, "ptr word");
		end
		wb(ADR_STAT, 1'b0, 0);
		chk(q & 32'h5, 32'h5, "stat");
		$display("t_sweep done");
	endtask
	task automatic t_fault();
		// Two channels only: channels 3 and 4 must keep their last words
		wb(ADR_CTRL, 1'b1, 32'h13);
		repeat (16) @(posedge ref_clk);
		fail <= 1'b1;
		repeat (80) @(posedge ref_clk);
		for (int i = 0; i < 4; i++) begin
			if (i < 2) begin
				chk({19'h0, hneg[i], hdata[i]}, 32'h1000, "fault word");
			end else begin
				chk({19'h0, hneg[i], hdata[i]}, {19'h0, 1'b1, mags[i]}, "unused channel");
			end
			wb(8'(ADR_PTR0 + ADR_PTR_STEP * i), 1'b0, 0);
			chk(q, 32'h8000, "fault ptr");
		end
		$display("t_fault done");
	endtask
	task automatic t_irq();
		fail <= 1'b0;
		wb(ADR_CTRL, 1'b1, 32'h30);
		wb(ADR_STAT, 1'b0, 0);
		wb(ADR_MASK, 1'b1, 32'h2);
		pins(2'b00);
		fail <= 1'b1;
		repeat (5) @(posedge ref_clk);
		pins(2'b10);
		wb(ADR_MASK, 1'b1, 32'h0);
		pins(2'b00);
		wb(ADR_STAT, 1'b0, 0);
		chk(q & 32'h2, 32'h2, "fault event");
		wb(ADR_MASK, 1'b1, 32'h2);
		pins(2'b00);
		fail <= 1'b0;
		$display("t_irq done");
	endtask
	task automatic results();
		$display("compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		t_regs();
		t_sweep(1'b0);
		t_sweep(1'b1);
		t_fault();
		t_irq();
		results();
	end
	initial begin
		repeat (3000) @(posedge ref_clk);
		error_cnt++;
		results();
	end
endmodule
`default_nettype wire
